// file: mor_pkg.sv
/*
 * Shared constants and carriers for the option and remote-control bank.
 * Assumes a command engine on sys_clk that hands over command codes,
 * write data bytes (low byte first) and the packet-check verdict.
 */
`default_nettype none
package mor_pkg;
   // ************************************************************
   // Command codes
   // ************************************************************
   localparam logic [7:0] CMD_SPECIAL  = 8'he0;
   localparam logic [7:0] CMD_TEMP_INT = 8'he1;
   localparam logic [7:0] CMD_TEMP_CAL = 8'he2;
   localparam logic [7:0] CMD_REMOTE   = 8'he3;
   localparam logic [7:0] CMD_FFWD     = 8'he6;
   localparam logic [7:0] CMD_TCOMP    = 8'he7;
   localparam logic [7:0] CMD_FILTER   = 8'he8;
   // ************************************************************
   // Byte lengths
   // ************************************************************
   localparam logic [4:0] LEN_SPECIAL  = 5'h01;
   localparam logic [4:0] LEN_TEMP_INT = 5'h02;
   localparam logic [4:0] LEN_TEMP_CAL = 5'h04;
   localparam logic [4:0] LEN_REMOTE   = 5'h01;
   localparam logic [4:0] LEN_FFWD     = 5'h04;
   localparam logic [4:0] LEN_TCOMP    = 5'h06;
   localparam logic [4:0] LEN_FILTER   = 5'h1b;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int SPC_PEC_BIT   = 7;
   localparam int SPC_DROOP_BIT = 5;
   localparam int SPC_RAMP_BIT  = 3;
   localparam int SPC_BUSV_BIT  = 2;
   localparam int RMT_AND_BIT   = 4;
   localparam int RMT_EN_BIT    = 2;
   localparam int RMT_POL_BIT   = 1;
   localparam int RMT_QOFF_BIT  = 0;
   localparam logic [7:0] SPC_MASK = 8'ha4 | 8'h08;
   localparam logic [7:0] RMT_MASK = 8'h17;
   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [7:0]   RST_SPECIAL = 8'h00;
   localparam logic [7:0]   RST_REMOTE  = 8'h00;
   localparam logic [7:0]   RST_CMD     = 8'h00;
   localparam logic [31:0]  RST_FFWD    = 32'h00000000;
   localparam logic [215:0] RST_FILTER  = 216'h0;
   localparam logic [7:0]   RST_RDATA   = 8'h00;
   localparam logic [4:0]   RST_CNT     = 5'h00;
   // ************************************************************
   // Carriers
   // ************************************************************
   typedef enum logic [1:0] {WR_IDLE, WR_COLLECT, WR_DROP} mor_wr_e;
   typedef struct packed {
      logic [7:0] setting;
      logic [7:0] high_gain_thresh;
      logic [7:0] high_gain;
      logic [7:0] ref_adjust_thresh;
   } mor_ffwd_s;
   typedef struct packed {
      logic [7:0]  level2_factor;
      logic [7:0]  level2_temp;
      logic [7:0]  level1_factor;
      logic [7:0]  level1_temp;
      logic [15:0] copper_coeff;
   } mor_tcomp_s;
   typedef struct packed {
      logic [15:0] internal_temp_offset;
      logic [15:0] remote_slope;
      logic [15:0] remote_offset;
      mor_tcomp_s  tcomp;
   } mor_cal_s;
   typedef struct packed {
      logic [4:0]        control_accel_scale;
      logic [2:0]        output_term_scale;
      logic [15:0]       kcomp;
      logic [1:0][15:0]  derivative_alpha;
      logic [2:0][15:0]  derivative_coefficient;
      logic [3:0][15:0]  integral_coefficient;
      logic [2:0][15:0]  proportional_coefficient;
   } mor_filter_s;
endpackage
`default_nettype wire

// file: mor_regs.sv
/*
 * Option, remote-control and calibration register bank on command codes.
 * Assumes the command engine on sys_clk; remote and control pins are
 * asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module mor_regs
   import mor_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        txn_start,
   input  wire logic [7:0]  txn_cmd,
   input  wire logic        wr_byte_valid,
   input  wire logic [7:0]  wr_byte,
   input  wire logic        wr_end,
   input  wire logic        wr_pec_good,
   input  wire logic        rd_req,
   input  wire logic [4:0]  rd_index,
   input  wire mor_cal_s    cal_in,
   input  wire logic        remote_on_off_pin,
   input  wire logic        ctrl_pin,
   input  wire logic        operation_on,
   output logic             rd_valid,
   output logic [7:0]       rd_data,
   output logic [4:0]       rd_len,
   output logic             cmd_unknown,
   output logic             pec_required,
   output logic             droop_slope_select,
   output logic             adaptive_ramp_loop_comp,
   output logic             dynamic_bus_voltage,
   output logic             output_run,
   output logic             quick_off,
   output mor_ffwd_s        ffwd_out,
   output mor_filter_s      filter_out
);
   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0]   cmd_reg;
   logic [7:0]   special_reg;
   logic [7:0]   remote_reg;
   logic [31:0]  ffwd_reg;
   logic [215:0] filter_reg;
   logic [215:0] stage_reg;
   logic [4:0]   cnt_reg;
   mor_wr_e      wr_state_reg;
   mor_wr_e      wr_state_next;
   logic         wr_commit;
   logic [4:0]   cur_len;
   logic [215:0] rd_vec;
   logic         pin_meta_reg;
   logic         pin_sync_reg;
   logic         ctl_meta_reg;
   logic         ctl_sync_reg;
   logic         run_next;
   logic         pin_active;
   logic         op_ctrl;
   logic         rd_valid_reg;
   logic [7:0]   rd_data_reg;
   logic [4:0]   rd_len_reg;
   logic         unknown_reg;
   logic         run_reg;

   function automatic logic [4:0] len_of(input logic [7:0] c);
      unique case (c)
         CMD_SPECIAL:  return LEN_SPECIAL;
         CMD_TEMP_INT: return LEN_TEMP_INT;
         CMD_TEMP_CAL: return LEN_TEMP_CAL;
         CMD_REMOTE:   return LEN_REMOTE;
         CMD_FFWD:     return LEN_FFWD;
         CMD_TCOMP:    return LEN_TCOMP;
         CMD_FILTER:   return LEN_FILTER;
         default:      return RST_CNT;
      endcase
   endfunction

   function automatic logic is_writable(input logic [7:0] c);
      return (c == CMD_SPECIAL) || (c == CMD_REMOTE) ||
             (c == CMD_FFWD) || (c == CMD_FILTER);
   endfunction

   assign cur_len = len_of(cmd_reg);

   // ************************************************************
   // Command capture
   // ************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_reg <= RST_CMD;
      end else if (txn_start) begin
         cmd_reg <= txn_cmd;
      end
   end

   // ************************************************************
   // Write collection
   // ************************************************************
   always_comb begin
      wr_state_next = wr_state_reg;
      if (txn_start) begin
         wr_state_next = is_writable(txn_cmd) ? WR_COLLECT : WR_DROP;
      end else if (wr_end) begin
         wr_state_next = WR_IDLE;
      end else if (wr_byte_valid && wr_state_reg == WR_COLLECT &&
                   cnt_reg >= cur_len) begin
         wr_state_next = WR_DROP;
      end
   end

   assign wr_commit = wr_end && wr_state_reg == WR_COLLECT &&
                      cnt_reg == cur_len &&
                      (!special_reg[SPC_PEC_BIT] || wr_pec_good);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_state_reg <= WR_IDLE;
      end else begin
         wr_state_reg <= wr_state_next;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg   <= RST_CNT;
         stage_reg <= RST_FILTER;
      end else if (txn_start) begin
         cnt_reg   <= RST_CNT;
      end else if (wr_byte_valid && wr_state_reg == WR_COLLECT &&
                   cnt_reg < cur_len) begin
         stage_reg[{cnt_reg, 3'b000} +: 8] <= wr_byte;
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // ************************************************************
   // Writable registers
   // ************************************************************
   // option bits with masked reserved
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         special_reg <= RST_SPECIAL;
      end else if (wr_commit && cmd_reg == CMD_SPECIAL) begin
         special_reg <= stage_reg[7:0] & SPC_MASK;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         remote_reg <= RST_REMOTE;
      end else if (wr_commit && cmd_reg == CMD_REMOTE) begin
         remote_reg <= stage_reg[7:0] & RMT_MASK;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ffwd_reg <= RST_FFWD;
      end else if (wr_commit && cmd_reg == CMD_FFWD) begin
         ffwd_reg <= stage_reg[31:0];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         filter_reg <= RST_FILTER;
      end else if (wr_commit && cmd_reg == CMD_FILTER) begin
         filter_reg <= stage_reg;
      end
   end

   assign pec_required            = special_reg[SPC_PEC_BIT];
   assign droop_slope_select      = special_reg[SPC_DROOP_BIT];
   assign adaptive_ramp_loop_comp = special_reg[SPC_RAMP_BIT];
   assign dynamic_bus_voltage     = special_reg[SPC_BUSV_BIT];
   assign quick_off               = remote_reg[RMT_QOFF_BIT];
   assign filter_out              = mor_filter_s'(filter_reg);
   assign ffwd_out                = mor_ffwd_s'(ffwd_reg);

   // ************************************************************
   // Read path
   // ************************************************************
   // calibration and block readback
   always_comb begin
      rd_vec = '0;
      unique case (cmd_reg)
         CMD_SPECIAL:  rd_vec[7:0]  = special_reg;
         CMD_TEMP_INT: rd_vec[15:0] = cal_in.internal_temp_offset;
         CMD_TEMP_CAL: rd_vec[31:0] = {cal_in.remote_slope,
                                       cal_in.remote_offset};
         CMD_REMOTE:   rd_vec[7:0]  = remote_reg;
         CMD_FFWD:     rd_vec[31:0] = ffwd_reg;
         CMD_TCOMP:    rd_vec[47:0] = cal_in.tcomp;
         CMD_FILTER:   rd_vec       = filter_reg;
         default:      rd_vec       = '0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= RST_RDATA;
         rd_len_reg   <= RST_CNT;
         unknown_reg  <= 1'b0;
      end else begin
         rd_valid_reg <= rd_req;
         if (rd_req) begin
            rd_len_reg  <= cur_len;
            unknown_reg <= (cur_len == RST_CNT);
            rd_data_reg <= (rd_index < cur_len) ?
                           rd_vec[{rd_index, 3'b000} +: 8] : RST_RDATA;
         end
      end
   end

   assign rd_valid    = rd_valid_reg;
   assign rd_data     = rd_data_reg;
   assign rd_len      = rd_len_reg;
   assign cmd_unknown = unknown_reg;

   // ************************************************************
   // Remote on/off combination
   // ************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         ctl_meta_reg <= 1'b0;
         ctl_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= remote_on_off_pin;
         pin_sync_reg <= pin_meta_reg;
         ctl_meta_reg <= ctrl_pin;
         ctl_sync_reg <= ctl_meta_reg;
      end
   end

   assign pin_active = (pin_sync_reg == remote_reg[RMT_POL_BIT]);
   assign op_ctrl   = operation_on && ctl_sync_reg;

   always_comb begin
      run_next = op_ctrl;
      if (remote_reg[RMT_EN_BIT]) begin
         run_next = remote_reg[RMT_AND_BIT] ? (pin_active && op_ctrl)
                                            : (pin_active || op_ctrl);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= run_next;
      end
   end

   assign output_run = run_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_pec_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_end && special_reg[SPC_PEC_BIT] && !wr_pec_good |=>
      $stable(special_reg) && $stable(remote_reg) &&
      $stable(ffwd_reg) && $stable(filter_reg))
      else $error("write taken despite bad check");
   a_pec_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_commit && cmd_reg == CMD_SPECIAL |=>
      pec_required == $past(stage_reg[SPC_PEC_BIT]))
      else $error("check flag not updated");
   a_droop_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_commit && cmd_reg == CMD_SPECIAL |=>
      droop_slope_select == $past(stage_reg[SPC_DROOP_BIT]))
      else $error("droop select wrong");
   a_ramp_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_commit && cmd_reg == CMD_SPECIAL |=>
      adaptive_ramp_loop_comp == $past(stage_reg[SPC_RAMP_BIT]))
      else $error("adaptive ramp bit wrong");
   a_busv_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_commit && cmd_reg == CMD_SPECIAL |=>
      dynamic_bus_voltage == $past(stage_reg[SPC_BUSV_BIT]))
      else $error("bus voltage bit wrong");
   a_resvd_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_valid && cmd_reg == CMD_SPECIAL && $past(rd_index) == 5'h00 |->
      rd_data[1:0] == 2'b00)
      else $error("reserved bits read nonzero");
   a_combine_and: assert property (@(posedge sys_clk) disable iff (sys_rst)
      remote_reg[RMT_EN_BIT] && remote_reg[RMT_AND_BIT] && !op_ctrl |=>
      !output_run)
      else $error("AND mode ran without control");
   a_pin_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !remote_reg[RMT_EN_BIT] |=> output_run == $past(op_ctrl))
      else $error("disabled pin affected run");
   a_polarity: assert property (@(posedge sys_clk) disable iff (sys_rst)
      remote_reg[RMT_EN_BIT] && !remote_reg[RMT_AND_BIT] && !op_ctrl |=>
      output_run == ($past(pin_sync_reg) == $past(remote_reg[RMT_POL_BIT])))
      else $error("pin polarity wrong");
   a_off_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_commit && cmd_reg == CMD_REMOTE |=>
      quick_off == $past(stage_reg[RMT_QOFF_BIT]))
      else $error("off mode not updated");
   a_cal_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_req && cmd_reg == CMD_TEMP_CAL && rd_index == 5'h02 |=>
      rd_valid && rd_len == LEN_TEMP_CAL &&
      rd_data == $past(cal_in.remote_slope[7:0]))
      else $error("calibration slope byte wrong");
   a_tcomp_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_req && cmd_reg == CMD_TCOMP && rd_index == 5'h05 |=>
      rd_data == $past(cal_in.tcomp.level2_factor))
      else $error("level 2 factor byte wrong");
   a_copper_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_req && cmd_reg == CMD_TCOMP && rd_index == 5'h00 |=>
      rd_data == $past(cal_in.tcomp.copper_coeff[7:0]))
      else $error("copper coefficient byte wrong");
   a_ffwd_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_req && cmd_reg == CMD_FFWD |=> rd_len == LEN_FFWD)
      else $error("feed-forward length wrong");
   a_filter_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_req && cmd_reg == CMD_FILTER |=> rd_len == LEN_FILTER)
      else $error("filter length wrong");
   a_top_scales: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_req && cmd_reg == CMD_FILTER && rd_index == 5'h1a |=>
      rd_data == {$past(filter_out.control_accel_scale),
                  $past(filter_out.output_term_scale)})
      else $error("top filter byte wrong");
   c_filter_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
      wr_commit && cmd_reg == CMD_FILTER);
   c_pec_reject: cover property (@(posedge sys_clk) disable iff (sys_rst)
      wr_end && special_reg[SPC_PEC_BIT] && !wr_pec_good);
   c_and_run: cover property (@(posedge sys_clk) disable iff (sys_rst)
      remote_reg[RMT_EN_BIT] && remote_reg[RMT_AND_BIT] && output_run);
endmodule
`default_nettype wire

// file: mor_host_model.sv
/*
 * Command engine model on the host side of the option register bank.
 * Assumes the bench calls its tasks; all lines change at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module mor_host_model (
   input  wire logic       sys_clk,
   output logic            txn_start,
   output logic [7:0]      txn_cmd,
   output logic            wr_byte_valid,
   output logic [7:0]      wr_byte,
   output logic            wr_end,
   output logic            wr_pec_good,
   output logic            rd_req,
   output logic [4:0]      rd_index,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data
);
   // ************************************************************
   // Bus tasks
   // ************************************************************
   initial begin
      {txn_start, wr_byte_valid, wr_end, rd_req} = 4'h0;
      {txn_cmd, wr_byte, rd_index, wr_pec_good} = 22'h0;
   end

   task automatic start_cmd(input logic [7:0] cmd);
      @(negedge sys_clk);
      txn_start = 1'b1;
      txn_cmd = cmd;
      @(negedge sys_clk);
      txn_start = 1'b0;
      txn_cmd = ~cmd;
   endtask

   // host sends whole bytes, reserved bits included
   task automatic write_cmd(input logic [7:0] cmd, input logic [215:0] d,
                            input int n, input logic pec);
      start_cmd(cmd);
      for (int i = 0; i < n; i++) begin
         wr_byte_valid = 1'b1;
         wr_byte = d[8*i +: 8];
         @(negedge sys_clk);
      end
      wr_byte_valid = 1'b0;
      wr_byte = ~wr_byte;
      wr_end = 1'b1;
      wr_pec_good = pec;
      @(negedge sys_clk);
      wr_end = 1'b0;
      wr_pec_good = ~pec;
      @(negedge sys_clk);
   endtask

   task automatic read_block(input logic [7:0] cmd, input int n,
                             output logic [215:0] v);
      v = '0;
      start_cmd(cmd);
      for (int i = 0; i < n; i++) begin
         rd_req = 1'b1;
         rd_index = 5'(i);
         @(negedge sys_clk);
         v[8*i +: 8] = (rd_valid === 1'b1) ? rd_data : 8'hxx;
      end
      rd_req = 1'b0;
      rd_index = ~rd_index;
   endtask
endmodule
`default_nettype wire

// file: mor_regs_tb_top.sv
/*
 * Self-checking bench for the option and remote-control register bank.
 * Assumes the host model drives the command side; pins come from here.
 */
`timescale 1ns/1ps
`default_nettype none
module mor_regs_tb_top
   import mor_pkg::*;
;
   logic sys_clk, sys_rst, txn_start, wr_byte_valid, wr_end, wr_pec_good;
   logic rd_req, remote_on_off_pin, ctrl_pin, operation_on, rd_valid;
   logic cmd_unknown, pec_required, droop_slope_select, quick_off;
   logic adaptive_ramp_loop_comp, dynamic_bus_voltage, output_run;
   logic [7:0]   txn_cmd, wr_byte, rd_data;
   logic [4:0]   rd_index, rd_len;
   logic [215:0] v, filt;
   mor_cal_s     cal_in;
   mor_ffwd_s    ffwd_out;
   mor_filter_s  filter_out;
   int           n_mismatch, n_tests;
   logic         opc, act, exp_run;

   // ************************************************************
   // Instances and clock
   // ************************************************************
   mor_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .txn_start(txn_start), .txn_cmd(txn_cmd),
      .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .wr_end(wr_end),
      .wr_pec_good(wr_pec_good), .rd_req(rd_req), .rd_index(rd_index),
      .cal_in(cal_in), .remote_on_off_pin(remote_on_off_pin),
      .ctrl_pin(ctrl_pin), .operation_on(operation_on),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_len(rd_len),
      .cmd_unknown(cmd_unknown), .pec_required(pec_required),
      .droop_slope_select(droop_slope_select),
      .adaptive_ramp_loop_comp(adaptive_ramp_loop_comp),
      .dynamic_bus_voltage(dynamic_bus_voltage), .output_run(output_run),
      .quick_off(quick_off), .ffwd_out(ffwd_out), .filter_out(filter_out));

   mor_host_model host (.sys_clk(sys_clk), .txn_start(txn_start),
      .txn_cmd(txn_cmd), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
      .wr_end(wr_end), .wr_pec_good(wr_pec_good), .rd_req(rd_req),
      .rd_index(rd_index), .rd_valid(rd_valid), .rd_data(rd_data));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ************************************************************
   // Checking and verdict
   // ************************************************************
   task automatic check_val(input logic [223:0] seen, input logic [223:0] e);
      n_tests++;
      if (seen !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, e);
      end
   endtask

   task automatic complete_run();
      if (n_mismatch == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #200000;
      n_mismatch++;
      complete_run();
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      {remote_on_off_pin, ctrl_pin, operation_on} = 3'h0;
      cal_in = {16'h1a2b, 16'h3c4d, 16'h5e6f, 48'h91827364a5b6};
      for (int i = 0; i < 27; i++) filt[8*i +: 8] = 8'(8'h3b + i * 29);
      repeat (8) @(negedge sys_clk);
      sys_rst = 1'b0;
      // Values after reset
      host.read_block(CMD_SPECIAL, 1, v);
      check_val(v, 216'h0);
      host.read_block(CMD_FILTER, 27, v);
      check_val(v, RST_FILTER);
      check_val({pec_required, quick_off, ffwd_out}, '0);
      // Option bits, reserved bits dropped
      host.write_cmd(CMD_SPECIAL, 216'hff, 1, 1'b1);
      host.read_block(CMD_SPECIAL, 1, v);
      check_val(v, 216'hac);
      check_val(pec_required, 1'b1);
      check_val(droop_slope_select, 1'b1);
      check_val(adaptive_ramp_loop_comp, 1'b1);
      check_val(dynamic_bus_voltage, 1'b1);
      // Bad check byte while required
      host.write_cmd(CMD_REMOTE, 216'h17, 1, 1'b0);
      host.read_block(CMD_REMOTE, 1, v);
      check_val(v, 216'h0);
      host.write_cmd(CMD_REMOTE, 216'hff, 1, 1'b1);
      host.read_block(CMD_REMOTE, 1, v);
      check_val(v, 216'h17);
      check_val(quick_off, 1'b1);
      host.write_cmd(CMD_SPECIAL, 216'h20, 1, 1'b1);
      check_val({pec_required, droop_slope_select}, 2'h1);
      check_val({adaptive_ramp_loop_comp, dynamic_bus_voltage}, 2'h0);
      host.write_cmd(CMD_SPECIAL, 216'h0, 1, 1'b0);
      check_val({droop_slope_select, dynamic_bus_voltage}, 2'h0);
      // Read-only and wrong-length writes
      host.write_cmd(CMD_TEMP_INT, 216'h0, 2, 1'b0);
      host.read_block(CMD_TEMP_INT, 2, v);
      check_val(v, 216'h1a2b);
      host.write_cmd(CMD_FFWD, 216'h112233, 3, 1'b0);
      host.read_block(CMD_FFWD, 4, v);
      check_val(v, 216'h0);
      host.write_cmd(CMD_FFWD, 216'h11223344, 4, 1'b0);
      check_val(ffwd_out, 32'h11223344);
      check_val(ffwd_out.ref_adjust_thresh, 8'h44);
      host.read_block(CMD_FFWD, 4, v);
      check_val({rd_len, v[31:0]}, {LEN_FFWD, 32'h11223344});
      // Filter block
      host.write_cmd(CMD_FILTER, filt, 27, 1'b0);
      check_val(filter_out, filt);
      check_val(filter_out.control_accel_scale, filt[215:211]);
      check_val(filter_out.output_term_scale, filt[210:208]);
      host.read_block(CMD_FILTER, 27, v);
      check_val({rd_len, v}, {LEN_FILTER, filt});
      // Calibration blocks
      host.read_block(CMD_TEMP_CAL, 4, v);
      check_val({rd_len, v}, {LEN_TEMP_CAL, 216'h3c4d5e6f});
      host.read_block(CMD_TCOMP, 6, v);
      check_val({rd_len, v}, {LEN_TCOMP, 216'h91827364a5b6});
      check_val(v[15:0], 16'ha5b6);
      host.read_block(8'he4, 1, v);
      check_val({cmd_unknown, rd_len, v}, {1'b1, 5'h0, 216'h0});
      // Remote pin combinations
      for (int k = 0; k < 128; k++) begin
         if (k[2:0] == 3'h0)
            host.write_cmd(CMD_REMOTE, {k[6], 1'b0, k[5:3]}, 1, 1'b0);
         @(negedge sys_clk);
         {remote_on_off_pin, operation_on, ctrl_pin} = k[2:0];
         repeat (5) @(negedge sys_clk);
         opc = k[1] & k[0];
         act = (k[2] == k[4]);
         exp_run = !k[5] ? opc : (k[6] ? (act & opc) : (act | opc));
         check_val(output_run, exp_run);
         check_val(quick_off, k[3]);
      end
      complete_run();
   end
endmodule
`default_nettype wire
